// File: hdl/sofb_pkg.sv
// shared constants, types and register map of the safety output block
package sofb_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;

  // contactor response time and its count at the system clock
  localparam int FBM_TIMEOUT_MS  = 300;
  localparam int CLK_KHZ         = 50000;
  localparam int FBM_TIMEOUT_CYC = FBM_TIMEOUT_MS * CLK_KHZ;

  // loop-back pulse phase length, input filter depth, good samples to enter bypass
  localparam int PULSE_CYC    = 64;
  localparam int FILT_LEN_DEF = 4;
  localparam int LOOP_GOOD_N  = 2;

  // filtered input bit positions
  localparam int IN_LB_A = 0;
  localparam int IN_LB_B = 1;
  localparam int IN_FB   = 2;
  localparam int IN_RST  = 3;
  localparam int IN_W    = 4;

  // pulse phases in which one loop-back output is high
  localparam logic [1:0] PH_A = 2'h0;
  localparam logic [1:0] PH_B = 2'h2;

  // display codes
  localparam logic [3:0] DISP_OK         = 4'h0;
  localparam logic [3:0] DISP_FBM_FAULT  = 4'h3;
  localparam logic [3:0] DISP_FBM_WIRING = 4'hB;
  localparam logic [3:0] DISP_BYPASS_ERR = 4'hC;
  localparam logic [3:0] DISP_WAIT       = 4'hE;

  // status register bit positions
  localparam int STB_ON     = 0;
  localparam int STB_BYPASS = 1;
  localparam int STB_LOCK   = 2;
  localparam int STB_WIRING = 3;
  localparam int STB_BPERR  = 4;
  localparam int STB_EDMF   = 5;
  localparam int STB_FB     = 6;
  localparam int STB_WAIT   = 7;

  typedef struct packed {
    logic bypass_en;
    logic fbm_en;
    logic configured;
  } sofb_ctrl_t;

  typedef struct packed {
    logic bp_implaus;
    logic bp_broken;
    logic bp_enter;
    logic fbm_wiring;
    logic contactor;
    logic fbm_timeout;
  } sofb_evt_t;

  localparam int CTRL_W = 3;
  localparam int EVT_W  = 6;

  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
  localparam logic [EVT_W-1:0]  EVT_RST  = 6'h00;

  typedef enum logic [2:0] {
    ST_WAIT_CFG,
    ST_INTERLOCK,
    ST_FBM_CHECK,
    ST_RUN,
    ST_BYPASS,
    ST_LOCKOUT
  } sofb_state_t;

endpackage

// File: hdl/sofb_in_filter.sv
// two-flop synchroniser and run-length filter for each pin input
`timescale 1ns/1ps
module sofb_in_filter #(
  parameter int W   = 4,
  parameter int LEN = 4
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      logic           s1_q;
      logic           s2_q;
      logic [LEN-1:0] hist_q;
      logic           out_q;

      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
        end
        else
        begin
          s1_q <= din[g];
          s2_q <= s1_q;
        end
      end

      // output moves only after LEN equal samples, so a short glitch is ignored
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          hist_q <= '0;
          out_q  <= 1'b0;
        end
        else
        begin
          hist_q <= {hist_q[LEN-2:0], s2_q};
          if (&hist_q)
            out_q <= 1'b1;
          else if (~|hist_q)
            out_q <= 1'b0;
        end
      end

      assign dout[g] = out_q;
    end
  endgenerate

endmodule

// File: hdl/sofb_core.sv
// safety switching outputs with contactor feedback monitor and bypass loop
// Operation
// - feedback response within 300 ms else off
// - missing feedback after trip blocks restart
// - feedback wired but option off shows B
// - bypass holds outputs on, indicators off
// - bypass holds speed and teach requests inactive
// - bypass needs option and looped-back pulses
// - broken loop locks out until power-up
// - implausible loop inputs raise error code C
// - both loop-back outputs driven with pulses
// - outputs off while waiting for configuration
`timescale 1ns/1ps
module sofb_core #(
  parameter int FBM_TIMEOUT_CYCLES = sofb_pkg::FBM_TIMEOUT_CYC,
  parameter int PULSE_CYCLES       = sofb_pkg::PULSE_CYC,
  parameter int FILT_LEN           = sofb_pkg::FILT_LEN_DEF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        protect_clear,
  input  wire logic        speed_req_src,
  input  wire logic        teach_req_src,
  input  wire logic        reset_request,
  input  wire logic        contactor_feedback_monitor,
  input  wire logic        loopback_in_a,
  input  wire logic        loopback_in_b,
  output logic             safety_switch_out_a,
  output logic             safety_switch_out_b,
  output logic             loopback_pulse_out_a,
  output logic             loopback_pulse_out_b,
  output logic             target_speed_request,
  output logic             teach_request,
  output logic             display_on,
  output logic      [3:0]  display_code,
  output logic             irq
);

  localparam int TW = $clog2(FBM_TIMEOUT_CYCLES + 1);
  localparam int PW = $clog2(PULSE_CYCLES + 1);
  localparam logic [TW-1:0] TMR_LAST  = TW'(FBM_TIMEOUT_CYCLES - 1);
  localparam logic [PW-1:0] PCNT_LAST = PW'(PULSE_CYCLES - 1);
  localparam logic [1:0]    GOOD_N    = 2'(sofb_pkg::LOOP_GOOD_N);

  sofb_pkg::sofb_ctrl_t  ctrl_q;
  sofb_pkg::sofb_evt_t   ev;
  sofb_pkg::sofb_evt_t   stat_q;
  sofb_pkg::sofb_evt_t   mask_q;
  sofb_pkg::sofb_state_t state_q;
  sofb_pkg::sofb_state_t state_d;

  logic [sofb_pkg::IN_W-1:0] raw_in;
  logic [sofb_pkg::IN_W-1:0] filt;
  logic                      fb;
  logic                      lb_a;
  logic                      lb_b;
  logic                      rst_f_q;
  logic                      reset_edge;
  logic [TW-1:0]             tmr_q;
  logic [PW-1:0]             pcnt_q;
  logic [1:0]                phase_q;
  logic                      pulse_a_q;
  logic                      pulse_b_q;
  logic                      samp;
  logic                      implaus;
  logic                      miss;
  logic                      broken;
  logic [1:0]                good_q;
  logic                      loop_ok;
  logic                      bp_enter_ok;
  logic                      on_d;
  logic                      req_ok;
  logic                      wiring_q;
  logic                      bperr_q;
  logic                      edmf_q;
  logic                      out_a_q;
  logic                      out_b_q;
  logic                      spd_q;
  logic                      teach_q;
  logic                      disp_on_q;
  logic [3:0]                disp_q;
  logic [3:0]                disp_d;
  logic [31:0]               prdata_q;
  logic [31:0]               rd_mux;
  logic                      hit;
  logic                      setup_rd;
  logic                      acc;
  logic                      wr_en;
  logic                      rd_clr;

  // ---------------- input conditioning
  assign raw_in[sofb_pkg::IN_LB_A] = loopback_in_a;
  assign raw_in[sofb_pkg::IN_LB_B] = loopback_in_b;
  assign raw_in[sofb_pkg::IN_FB]   = contactor_feedback_monitor;
  assign raw_in[sofb_pkg::IN_RST]  = reset_request;

  sofb_in_filter #(
    .W   (sofb_pkg::IN_W),
    .LEN (FILT_LEN)
  ) u_filt (
    .clk   (pclk),
    .rst_n (presetn),
    .din   (raw_in),
    .dout  (filt)
  );

  assign fb   = filt[sofb_pkg::IN_FB];
  assign lb_a = filt[sofb_pkg::IN_LB_A];
  assign lb_b = filt[sofb_pkg::IN_LB_B];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rst_f_q <= 1'b0;
    else
      rst_f_q <= filt[sofb_pkg::IN_RST];
  end

  // a held reset button counts once
  assign reset_edge = filt[sofb_pkg::IN_RST] & ~rst_f_q;

  // ---------------- loop-back pulse generator
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pcnt_q  <= '0;
      phase_q <= sofb_pkg::PH_A;
    end
    else if (!ctrl_q.bypass_en)
    begin
      pcnt_q  <= '0;
      phase_q <= sofb_pkg::PH_A;
    end
    else if (pcnt_q == PCNT_LAST)
    begin
      pcnt_q  <= '0;
      phase_q <= phase_q + 2'h1;
    end
    else
      pcnt_q <= pcnt_q + PW'(1);
  end

  // outputs alternate with a gap, so a short between the loops is visible
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pulse_a_q <= 1'b0;
      pulse_b_q <= 1'b0;
    end
    else
    begin
      pulse_a_q <= ctrl_q.bypass_en & (phase_q == sofb_pkg::PH_A);
      pulse_b_q <= ctrl_q.bypass_en & (phase_q == sofb_pkg::PH_B);
    end
  end

  // sample at phase end, after the filter has settled on the returned level
  assign samp    = ctrl_q.bypass_en & (pcnt_q == PCNT_LAST);
  assign implaus = (lb_a & ~pulse_a_q) | (lb_b & ~pulse_b_q);
  assign miss    = (pulse_a_q & ~lb_a) | (pulse_b_q & ~lb_b);
  assign broken  = ~implaus & miss;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      good_q <= '0;
    else if (!ctrl_q.bypass_en)
      good_q <= '0;
    else if (samp && (implaus || miss))
      good_q <= '0;
    else if (samp && (pulse_a_q || pulse_b_q) && good_q != GOOD_N)
      good_q <= good_q + 2'h1;
  end

  assign loop_ok     = (good_q == GOOD_N);
  assign bp_enter_ok = ctrl_q.configured & ctrl_q.bypass_en & loop_ok;

  // ---------------- main sequence
  always_comb
  begin
    state_d = state_q;
    ev      = sofb_pkg::EVT_RST;
    case (state_q)
      sofb_pkg::ST_WAIT_CFG:
      begin
        if (ctrl_q.configured)
        begin
          // closed contacts read back with monitoring off: wiring fault
          if (!ctrl_q.fbm_en && fb)
          begin
            state_d       = sofb_pkg::ST_LOCKOUT;
            ev.fbm_wiring = 1'b1;
          end
          else
            state_d = sofb_pkg::ST_INTERLOCK;
        end
      end
      sofb_pkg::ST_INTERLOCK:
      begin
        if (bp_enter_ok)
        begin
          state_d     = sofb_pkg::ST_BYPASS;
          ev.bp_enter = 1'b1;
        end
        else if (reset_edge && protect_clear)
        begin
          if (ctrl_q.fbm_en && !fb)
            ev.contactor = 1'b1;
          else if (ctrl_q.fbm_en)
            state_d = sofb_pkg::ST_FBM_CHECK;
          else
            state_d = sofb_pkg::ST_RUN;
        end
      end
      sofb_pkg::ST_FBM_CHECK:
      begin
        if (!protect_clear)
          state_d = sofb_pkg::ST_INTERLOCK;
        else if (!fb)
          state_d = sofb_pkg::ST_RUN;
        else if (tmr_q == TMR_LAST)
        begin
          state_d        = sofb_pkg::ST_INTERLOCK;
          ev.fbm_timeout = 1'b1;
        end
      end
      sofb_pkg::ST_RUN:
      begin
        if (bp_enter_ok)
        begin
          state_d     = sofb_pkg::ST_BYPASS;
          ev.bp_enter = 1'b1;
        end
        else if (!protect_clear)
          state_d = sofb_pkg::ST_INTERLOCK;
      end
      sofb_pkg::ST_BYPASS:
      begin
        if (samp && implaus)
        begin
          state_d       = sofb_pkg::ST_LOCKOUT;
          ev.bp_implaus = 1'b1;
        end
        else if ((samp && broken) || !ctrl_q.bypass_en)
        begin
          state_d      = sofb_pkg::ST_LOCKOUT;
          ev.bp_broken = 1'b1;
        end
      end
      sofb_pkg::ST_LOCKOUT:
        state_d = sofb_pkg::ST_LOCKOUT;
      default:
        state_d = sofb_pkg::ST_WAIT_CFG;
    endcase
    if (state_q inside {sofb_pkg::ST_INTERLOCK, sofb_pkg::ST_FBM_CHECK, sofb_pkg::ST_RUN})
    begin
      if (!ctrl_q.configured)
      begin
        state_d     = sofb_pkg::ST_WAIT_CFG;
        ev.bp_enter = 1'b0;
      end
      else if (samp && implaus)
      begin
        state_d       = sofb_pkg::ST_LOCKOUT;
        ev            = sofb_pkg::EVT_RST;
        ev.bp_implaus = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= sofb_pkg::ST_WAIT_CFG;
    else
      state_q <= state_d;
  end

  // counted only while the response is awaited, which is entered only with monitoring on
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tmr_q <= '0;
    else if (state_q == sofb_pkg::ST_FBM_CHECK)
      tmr_q <= tmr_q + TW'(1);
    else
      tmr_q <= '0;
  end

  // fault flags; wiring and bypass faults stay until power-up
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wiring_q <= 1'b0;
      bperr_q  <= 1'b0;
      edmf_q   <= 1'b0;
    end
    else
    begin
      if (ev.fbm_wiring)
        wiring_q <= 1'b1;
      if (ev.bp_implaus)
        bperr_q <= 1'b1;
      if (ev.fbm_timeout || ev.contactor)
        edmf_q <= 1'b1;
      else if (state_d == sofb_pkg::ST_RUN)
        edmf_q <= 1'b0;
    end
  end

  // ---------------- pin outputs
  // both channels are driven alike from separate flops, never merged
  assign on_d   = state_d inside {sofb_pkg::ST_FBM_CHECK, sofb_pkg::ST_RUN, sofb_pkg::ST_BYPASS};
  assign req_ok = state_d inside {sofb_pkg::ST_INTERLOCK, sofb_pkg::ST_FBM_CHECK, sofb_pkg::ST_RUN};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_a_q <= 1'b0;
      out_b_q <= 1'b0;
    end
    else
    begin
      out_a_q <= on_d;
      out_b_q <= on_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      spd_q   <= 1'b0;
      teach_q <= 1'b0;
    end
    else
    begin
      spd_q   <= req_ok & speed_req_src;
      teach_q <= req_ok & teach_req_src;
    end
  end

  always_comb
  begin
    if (wiring_q || ev.fbm_wiring)
      disp_d = sofb_pkg::DISP_FBM_WIRING;
    else if (bperr_q || ev.bp_implaus)
      disp_d = sofb_pkg::DISP_BYPASS_ERR;
    else if (state_d == sofb_pkg::ST_WAIT_CFG)
      disp_d = sofb_pkg::DISP_WAIT;
    else if (edmf_q || ev.fbm_timeout || ev.contactor)
      disp_d = sofb_pkg::DISP_FBM_FAULT;
    else
      disp_d = sofb_pkg::DISP_OK;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      disp_q    <= sofb_pkg::DISP_WAIT;
      disp_on_q <= 1'b1;
    end
    else
    begin
      disp_q    <= disp_d;
      disp_on_q <= (state_d != sofb_pkg::ST_BYPASS);
    end
  end

  assign safety_switch_out_a  = out_a_q;
  assign safety_switch_out_b  = out_b_q;
  assign loopback_pulse_out_a = pulse_a_q;
  assign loopback_pulse_out_b = pulse_b_q;
  assign target_speed_request = spd_q;
  assign teach_request        = teach_q;
  assign display_on           = disp_on_q;
  assign display_code         = disp_q;

  // ---------------- apb slave
  assign hit      = paddr inside {sofb_pkg::OFF_CTRL, sofb_pkg::OFF_STATUS,
                                  sofb_pkg::OFF_IRQ_STAT, sofb_pkg::OFF_IRQ_MASK};
  assign setup_rd = psel & ~penable & ~pwrite;
  assign acc      = psel & penable;
  assign wr_en    = acc & pwrite & hit;
  assign rd_clr   = acc & ~pwrite & (paddr == sofb_pkg::OFF_IRQ_STAT);
  assign pready   = 1'b1;
  assign pslverr  = acc & ~hit;

  always_comb
  begin
    rd_mux = '0;
    case (paddr)
      sofb_pkg::OFF_CTRL:     rd_mux[sofb_pkg::CTRL_W-1:0] = ctrl_q;
      sofb_pkg::OFF_STATUS:
      begin
        rd_mux[sofb_pkg::STB_ON]     = out_a_q;
        rd_mux[sofb_pkg::STB_BYPASS] = (state_q == sofb_pkg::ST_BYPASS);
        rd_mux[sofb_pkg::STB_LOCK]   = (state_q == sofb_pkg::ST_LOCKOUT);
        rd_mux[sofb_pkg::STB_WIRING] = wiring_q;
        rd_mux[sofb_pkg::STB_BPERR]  = bperr_q;
        rd_mux[sofb_pkg::STB_EDMF]   = edmf_q;
        rd_mux[sofb_pkg::STB_FB]     = fb;
        rd_mux[sofb_pkg::STB_WAIT]   = (state_q == sofb_pkg::ST_WAIT_CFG);
      end
      sofb_pkg::OFF_IRQ_STAT: rd_mux[sofb_pkg::EVT_W-1:0] = stat_q;
      sofb_pkg::OFF_IRQ_MASK: rd_mux[sofb_pkg::EVT_W-1:0] = mask_q;
      default:                rd_mux = '0;
    endcase
  end

  // read data is caught in the setup cycle and held through the access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (setup_rd)
      prdata_q <= rd_mux;
  end

  assign prdata = prdata_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= sofb_pkg::CTRL_RST;
      mask_q <= sofb_pkg::EVT_RST;
    end
    else if (wr_en && paddr == sofb_pkg::OFF_CTRL)
      ctrl_q <= pwdata[sofb_pkg::CTRL_W-1:0];
    else if (wr_en && paddr == sofb_pkg::OFF_IRQ_MASK)
      mask_q <= pwdata[sofb_pkg::EVT_W-1:0];
  end

  // only bits that were returned are cleared, and a new event wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat_q <= sofb_pkg::EVT_RST;
    else if (rd_clr)
      stat_q <= (stat_q & ~prdata_q[sofb_pkg::EVT_W-1:0]) | ev;
    else
      stat_q <= stat_q | ev;
  end

  assign irq = |(stat_q & mask_q);

  // ---------------- checks
  sequence s_bp_break;
    state_q == sofb_pkg::ST_BYPASS && samp && broken;
  endsequence

  sequence s_lock_stays;
    (state_q == sofb_pkg::ST_LOCKOUT && !out_a_q && !out_b_q) [*8];
  endsequence

  a_fbm_timeout_off: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == sofb_pkg::ST_FBM_CHECK && tmr_q == TMR_LAST && fb && protect_clear
    && ctrl_q.configured && !(samp && implaus)
    |=> !safety_switch_out_a && !safety_switch_out_b && stat_q.fbm_timeout)
    else $error("outputs not off after contactor timeout");

  a_fbm_bounded: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == sofb_pkg::ST_FBM_CHECK |-> ctrl_q.fbm_en || $past(ctrl_q.fbm_en)
    || tmr_q < TMR_LAST)
    else $error("timer running without monitoring");

  a_restart_blocked: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == sofb_pkg::ST_INTERLOCK && ctrl_q.fbm_en && !fb && !bp_enter_ok
    |=> !safety_switch_out_a && !safety_switch_out_b)
    else $error("restart with missing contactor feedback");

  a_wiring_code: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(wiring_q) |-> display_code == sofb_pkg::DISP_FBM_WIRING
    && state_q == sofb_pkg::ST_LOCKOUT)
    else $error("wiring fault without code B");

  a_bypass_outs_on: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == sofb_pkg::ST_BYPASS |-> safety_switch_out_a && safety_switch_out_b
    && !display_on)
    else $error("bypass outputs or display wrong");

  a_bypass_req_off: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == sofb_pkg::ST_BYPASS |-> !target_speed_request && !teach_request)
    else $error("request output active in bypass");

  a_bypass_entry: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state_q == sofb_pkg::ST_BYPASS) |-> $past(ctrl_q.bypass_en) && $past(loop_ok))
    else $error("bypass entered without loop");

  a_break_lockout: assert property (@(posedge pclk) disable iff (!presetn)
    s_bp_break |=> s_lock_stays)
    else $error("broken loop did not lock out");

  a_implaus_code: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == sofb_pkg::ST_BYPASS && samp && implaus
    |=> display_code == sofb_pkg::DISP_BYPASS_ERR && state_q == sofb_pkg::ST_LOCKOUT)
    else $error("implausible loop without error code");

  a_pulse_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
    !(loopback_pulse_out_a && loopback_pulse_out_b)
    and (!ctrl_q.bypass_en |=> !loopback_pulse_out_a && !loopback_pulse_out_b))
    else $error("loop-back pulse pattern wrong");

  a_wait_outs_off: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_q.configured |=> ##1 !safety_switch_out_a && !safety_switch_out_b)
    else $error("outputs on while unconfigured");

endmodule

// File: verif/sofb_partner.sv
// far-side model: two positively driven contactors and the bypass loop wiring
`timescale 1ns/1ps
module sofb_partner (
  input  wire logic       pclk,
  input  wire logic [1:0] fmode,
  input  wire logic [1:0] lmode,
  input  wire logic       out_a,
  input  wire logic       out_b,
  input  wire logic       pulse_a,
  input  wire logic       pulse_b,
  output logic            fb,
  output logic            lb_a,
  output logic            lb_b
);
  logic [3:0] ka_q = 4'h0;
  logic [3:0] kb_q = 4'h0;
  // each output drives its own contactor coil, never merged
  always @(posedge pclk)
  begin
    ka_q <= {ka_q[2:0], out_a};
    kb_q <= {kb_q[2:0], out_b};
  end
  // fmode 1 welded contact, 2 coil never picks up; nc pair closed only when both drop
  assign fb = (fmode == 2'h1) ? 1'b0 : (fmode == 2'h2) ? 1'b1 : !(ka_q[3] | kb_q[3]);
  // lmode 0 wired, 1 cut (inputs pulled down), 2 crossed
  assign lb_a = (lmode == 2'h0) ? pulse_a : (lmode == 2'h2) ? pulse_b : 1'b0;
  assign lb_b = (lmode == 2'h0) ? pulse_b : (lmode == 2'h2) ? pulse_a : 1'b0;
endmodule

// File: verif/tb_safety_output_feedback_bypass.sv
// self-checking bench: register access, contactor feedback and bypass loop
`timescale 1ns/1ps
module tb_safety_output_feedback_bypass;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        pclr = 1'b0;
  logic        spd_src = 1'b0;
  logic        tch_src = 1'b0;
  logic        rst_req = 1'b0;
  logic [1:0]  fmode = 2'h0;
  logic [1:0]  lmode = 2'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [3:0]  code;
  logic        pready, pslverr, err, fb, lb_a, lb_b, so_a, so_b;
  logic        po_a, po_b, spd, tch, disp_on, irq;
  int          miscompares = 0;
  int          n_tests = 0;
  int          pa_n = 0;
  int          both_n = 0;

  sofb_core #(.FBM_TIMEOUT_CYCLES(50), .PULSE_CYCLES(16), .FILT_LEN(4)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .protect_clear(pclr), .speed_req_src(spd_src), .teach_req_src(tch_src),
    .reset_request(rst_req), .contactor_feedback_monitor(fb),
    .loopback_in_a(lb_a), .loopback_in_b(lb_b),
    .safety_switch_out_a(so_a), .safety_switch_out_b(so_b),
    .loopback_pulse_out_a(po_a), .loopback_pulse_out_b(po_b),
    .target_speed_request(spd), .teach_request(tch),
    .display_on(disp_on), .display_code(code), .irq(irq));

  sofb_partner far (
    .pclk(pclk), .fmode(fmode), .lmode(lmode), .out_a(so_a), .out_b(so_b),
    .pulse_a(po_a), .pulse_b(po_b), .fb(fb), .lb_a(lb_a), .lb_b(lb_b));

  initial forever #10 pclk = ~pclk;

  // pulse activity monitor: both loop outputs must never be high together
  always @(posedge pclk)
  begin
    pa_n <= pa_n + int'(po_a);
    both_n <= both_n + int'(po_a & po_b);
  end

  function automatic logic [31:0] evt(input int b);
    return 32'h0000_0001 << b;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // setup then access, held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rst();
    presetn <= 1'b0;
    tick(12);
    presetn <= 1'b1;
    tick(10);
  endtask

  // operator press long enough to pass the input filter
  task automatic attempt();
    rst_req <= 1'b1;
    tick(10);
    rst_req <= 1'b0;
  endtask

  task automatic done(input string s);
    $display("test done: %s", s);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    void'($urandom(32'h719d));
    rst();
    chk(code, sofb_pkg::DISP_WAIT);
    chk({so_a, so_b}, 2'h0);
    apb(1'b0, sofb_pkg::OFF_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(err, 1'b1);
    apb(1'b1, sofb_pkg::OFF_CTRL, 32'h0000_0001);
    tick(20);
    chk(code, sofb_pkg::DISP_FBM_WIRING);
    done("power-up and wiring");
    rst();
    apb(1'b1, sofb_pkg::OFF_CTRL, 32'h0000_0003);
    pclr <= 1'b1;
    attempt();
    tick(30);
    chk({so_a, so_b}, 2'h3);
    spd_src <= 1'($urandom);
    tch_src <= 1'($urandom);
    tick(3);
    chk({spd, tch}, {spd_src, tch_src});
    pclr <= 1'b0;
    fmode <= 2'h1;
    tick(15);
    pclr <= 1'b1;
    attempt();
    tick(30);
    chk({so_a, so_b}, 2'h0);
    apb(1'b0, sofb_pkg::OFF_IRQ_STAT, 32'h0000_0000);
    chk(rd, evt(1));
    chk(code, sofb_pkg::DISP_FBM_FAULT);
    fmode <= 2'h2;
    tick(15);
    attempt();
    tick(35);
    chk({so_a, so_b}, 2'h3);
    tick(30);
    chk({so_a, so_b}, 2'h0);
    apb(1'b0, sofb_pkg::OFF_IRQ_STAT, 32'h0000_0000);
    chk(rd, evt(0));
    done("contactor feedback");
    fmode <= 2'h0;
    rst();
    spd_src <= 1'b1;
    tch_src <= 1'b1;
    apb(1'b1, sofb_pkg::OFF_IRQ_MASK, 32'h0000_0010);
    apb(1'b1, sofb_pkg::OFF_CTRL, 32'h0000_0007);
    tick(300);
    chk({so_a, so_b}, 2'h3);
    chk(disp_on, 1'b0);
    chk({spd, tch}, 2'h0);
    chk(pa_n != 0, 1'b1);
    chk(both_n, 32'h0000_0000);
    lmode <= 2'h1;
    tick(1);
    lmode <= 2'h0;
    tick(100);
    chk({so_a, so_b}, 2'h3);
    lmode <= 2'h1;
    tick(200);
    chk({so_a, so_b}, 2'h0);
    chk(irq, 1'b1);
    apb(1'b0, sofb_pkg::OFF_STATUS, 32'h0000_0000);
    chk(rd[sofb_pkg::STB_LOCK], 1'b1);
    apb(1'b0, sofb_pkg::OFF_IRQ_STAT, 32'h0000_0000);
    chk(rd, evt(3) | evt(4));
    // the clear lands at the access edge, so look one cycle later
    tick(1);
    chk(irq, 1'b0);
    done("bypass entry and break");
    lmode <= 2'h2;
    rst();
    apb(1'b1, sofb_pkg::OFF_CTRL, 32'h0000_0007);
    tick(300);
    chk(code, sofb_pkg::DISP_BYPASS_ERR);
    chk({so_a, so_b}, 2'h0);
    done("crossed loop");
    lmode <= 2'h0;
    rst();
    apb(1'b1, sofb_pkg::OFF_CTRL, 32'h0000_0007);
    tick(300);
    chk({so_a, so_b}, 2'h3);
    lmode <= 2'h2;
    tick(100);
    chk(code, sofb_pkg::DISP_BYPASS_ERR);
    chk({so_a, so_b, disp_on}, 3'h1);
    done("loop crossed in bypass");
    report_and_stop();
  end

  initial
  begin
    tick(20000);
    miscompares++;
    report_and_stop();
  end
endmodule
